// ---- crw_defs.vh ----
// Constants for the coupled RAM wrapper: geometry, field positions, reset values.
// Assumes inclusion by bare name from the wrapper files.
`ifndef CRW_DEFS_VH
`define CRW_DEFS_VH
// ============================================================
// Geometry
`define CRW_ADDR_W 12
`define CRW_DATA_W 64
`define CRW_ECC_W 8
`define CRW_BANK_W 36
`define CRW_BANK_BYTES 4
// ============================================================
// Event bus field positions
`define CRW_EV_SBE 0
`define CRW_EV_MBE 1
`define CRW_EV_W 2
// ============================================================
// Reset values
`define CRW_ADDR_RST 1'b0
`define CRW_INIT_PATTERN 36'h000000000
// ============================================================
// RAM select bit of the memory init select word
`define CRW_INIT_SEL_BIT 0
`define CRW_TIME_STEP 1
`endif

// ---- crw_decode.v ----
// Redundant bank and ECC select decoder: two independent paths compared.
// Assumes a same-clock access strobe and byte enables from the wrapper.
`timescale 1ns/1ns
`include "crw_defs.vh"
module crw_decode (
    input wire req,
    input wire wr,
    input wire [7:0] be,
    output wire [1:0] bank_cs,
    output wire [1:0] ecc_cs,
    output wire [7:0] bank_we,
    output wire mismatch
);
    wire [1:0] cs_a;
    wire [1:0] cs_b;
    wire ecc_a;
    wire ecc_b;
    wire [7:0] we_b;
    // ============================================================
    // Path A: positive logic decode
    // Even byte lanes live in bank 0, odd byte lanes in bank 1
    assign cs_a[0] = req & ((|(be & 8'h55)) | ~wr);
    assign cs_a[1] = req & ((|(be & 8'haa)) | ~wr);
    assign ecc_a = req;
    // Path B: inverted form decode, must agree with path A
    assign cs_b[0] = ~(~req | (((be & 8'h55) == 8'h00) & wr));
    assign cs_b[1] = ~(~req | (((be & 8'haa) == 8'h00) & wr));
    assign ecc_b = ~(~req);
    assign we_b = ~({8{~req | ~wr}} | ~be);
    // Outputs from path A, compare flags a fault in either path
    assign bank_cs = cs_a;
    assign ecc_cs = {2{ecc_a}};
    assign bank_we = {8{req & wr}} & be;
    assign mismatch = (cs_a != cs_b) | (ecc_a != ecc_b) | (bank_we != we_b);
endmodule

// ---- crw_top.v ----
// Coupled RAM wrapper: slave on the core secondary memory port, two banks.
// Assumes core port signals on CLK; RAM arrays are held inside the module.
`timescale 1ns/1ns
`include "crw_defs.vh"
// Summary of operation
// - Serve every read and write from the core secondary memory port while READY is high (not during init).
// - Reads return 64-bit data plus the stored 8-bit ECC code.
// - Writes store the core ECC output lines alongside written data.
// - Raise separate single-bit and multibit interrupts from core event bus.
// - Capture the address of single-bit and multibit errors separately.
// - Check address parity on every core access outside init, flag mismatch as fault.
// - Decode bank and ECC selects twice and flag any disagreement.
// - Two 36-bit byte-interleaved banks, each with its own control signals.
// - Hardware auto-initialization writes every bank location including ECC.
// - No bit-wise access; smallest access is one byte.
// - Init starts only with global init enable and RAM select bit set.
module crw_top #(
    parameter AW = `CRW_ADDR_W
) (
    input wire CLK,
    input wire NRST,
    input wire REQ,
    input wire WR,
    input wire [AW-1:0] ADDR,
    input wire ADDR_PAR,
    input wire [7:0] BE,
    input wire [63:0] WDATA,
    input wire [7:0] WECC,
    input wire [1:0] EVENT,
    input wire INIT_GLOBAL_EN,
    input wire [15:0] INIT_SELECT,
    input wire SBE_CLR,
    input wire MBE_CLR,
    output wire READY,
    output reg [63:0] RDATA,
    output reg [7:0] RECC,
    output reg RVALID,
    output reg SBE_IRQ,
    output reg MBE_IRQ,
    output reg [AW-1:0] SBE_ADDR,
    output reg [AW-1:0] MBE_ADDR,
    output reg ADDR_PAR_ERR,
    output reg DECODE_ERR,
    output wire INIT_BUSY,
    output reg INIT_DONE,
    output wire [1:0] BANK_CS,
    output wire [1:0] ECC_CS,
    output wire [7:0] BANK_WE
);
    localparam DEPTH = 1 << AW;
    localparam ST_IDLE = 2'b01;
    localparam ST_INIT = 2'b10;
    reg [`CRW_BANK_W-1:0] bank0 [0:DEPTH-1];
    reg [`CRW_BANK_W-1:0] bank1 [0:DEPTH-1];
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [AW-1:0] init_addr_q;
    reg [AW-1:0] last_addr_q;
    wire init_on;
    wire acc;
    wire [AW-1:0] addr_mux;
    wire wr_mux;
    wire [7:0] be_mux;
    wire [`CRW_BANK_W-1:0] wword0;
    wire [`CRW_BANK_W-1:0] wword1;
    wire [`CRW_BANK_W-1:0] wmask0;
    wire [`CRW_BANK_W-1:0] wmask1;
    wire dec_mis;
    wire sbe_ev;
    wire mbe_ev;

    // ============================================================
    // Auto-initialization sequencer
    assign init_on = state_q == ST_INIT;
    assign INIT_BUSY = init_on;
    assign READY = ~init_on;

    // Next state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (INIT_GLOBAL_EN && INIT_SELECT[`CRW_INIT_SEL_BIT]) begin
                    state_d = ST_INIT;
                end
            end
            ST_INIT: begin
                if (init_addr_q == {AW{1'b1}}) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State, address counter, done flag
    always @(posedge CLK) begin
        if (!NRST) begin
            state_q <= ST_IDLE;
            init_addr_q <= {AW{`CRW_ADDR_RST}};
            INIT_DONE <= 1'b0;
        end else begin
            state_q <= state_d;
            if (init_on) begin
                init_addr_q <= init_addr_q + 1'b1;
                if (init_addr_q == {AW{1'b1}}) begin
                    INIT_DONE <= 1'b1;
                end
            end else if (state_d == ST_INIT) begin
                init_addr_q <= {AW{`CRW_ADDR_RST}};
                INIT_DONE <= 1'b0;
            end
        end
    end

    // ============================================================
    // Access path and redundant decode
    assign acc = (REQ & ~init_on) | init_on;
    assign addr_mux = init_on ? init_addr_q : ADDR;
    assign wr_mux = init_on | WR;
    assign be_mux = init_on ? 8'hff : BE;

    crw_decode u_dec (
        .req(acc),
        .wr(wr_mux),
        .be(be_mux),
        .bank_cs(BANK_CS),
        .ecc_cs(ECC_CS),
        .bank_we(BANK_WE),
        .mismatch(dec_mis)
    );

    // Byte interleave: even bytes to bank 0, odd bytes to bank 1, ECC nibbles
    assign wword0 = init_on ? `CRW_INIT_PATTERN :
        {WECC[3:0], WDATA[55:48], WDATA[39:32], WDATA[23:16], WDATA[7:0]};
    assign wword1 = init_on ? `CRW_INIT_PATTERN :
        {WECC[7:4], WDATA[63:56], WDATA[47:40], WDATA[31:24], WDATA[15:8]};

    // Per-byte write masks, one generate per bank lane
    genvar g;
    generate
        for (g = 0; g < `CRW_BANK_BYTES; g = g + 1) begin : g_lane
            assign wmask0[8*g+7:8*g] = {8{BANK_CS[0] & BANK_WE[2*g]}};
            assign wmask1[8*g+7:8*g] = {8{BANK_CS[1] & BANK_WE[2*g+1]}};
        end
    endgenerate

    // ECC nibbles written on any write to the word
    assign wmask0[35:32] = {4{ECC_CS[0] & wr_mux}};
    assign wmask1[35:32] = {4{ECC_CS[1] & wr_mux}};

    // Bank arrays, masked write from a single process so each array has one driver
    always @(posedge CLK) begin
        if (|wmask0) begin
            bank0[addr_mux] <= (bank0[addr_mux] & ~wmask0) | (wword0 & wmask0);
        end
        if (|wmask1) begin
            bank1[addr_mux] <= (bank1[addr_mux] & ~wmask1) | (wword1 & wmask1);
        end
    end

    // Read data and ECC, one cycle after the request
    always @(posedge CLK) begin
        if (!NRST) begin
            RDATA <= 64'h0;
            RECC <= 8'h00;
            RVALID <= 1'b0;
        end else begin
            RVALID <= REQ & ~WR & ~init_on;
            if (REQ && !WR && !init_on) begin
                RDATA <= {bank1[ADDR][31:24], bank0[ADDR][31:24],
                    bank1[ADDR][23:16], bank0[ADDR][23:16],
                    bank1[ADDR][15:8], bank0[ADDR][15:8],
                    bank1[ADDR][7:0], bank0[ADDR][7:0]};
                RECC <= {bank1[ADDR][35:32], bank0[ADDR][35:32]};
            end
        end
    end

    // ============================================================
    // Integrity checks: address parity and decoder agreement
    always @(posedge CLK) begin
        if (!NRST) begin
            ADDR_PAR_ERR <= 1'b0;
            DECODE_ERR <= 1'b0;
        end else begin
            ADDR_PAR_ERR <= REQ & ~init_on & ((^ADDR) != ADDR_PAR);
            DECODE_ERR <= dec_mis;
        end
    end

    // ============================================================
    // Error events: last access address kept for the core's late report
    assign sbe_ev = EVENT[`CRW_EV_SBE];
    assign mbe_ev = EVENT[`CRW_EV_MBE];

    // Track the address of the most recent core access
    always @(posedge CLK) begin
        if (!NRST) begin
            last_addr_q <= {AW{`CRW_ADDR_RST}};
        end else begin
            if (REQ && !init_on) begin
                last_addr_q <= ADDR;
            end
        end
    end

    // Sticky flags, set wins over clear, address frozen while flag set unless a clear comes with the event
    always @(posedge CLK) begin
        if (!NRST) begin
            SBE_IRQ <= 1'b0;
            MBE_IRQ <= 1'b0;
            SBE_ADDR <= {AW{`CRW_ADDR_RST}};
            MBE_ADDR <= {AW{`CRW_ADDR_RST}};
        end else begin
            if (sbe_ev) begin
                SBE_IRQ <= 1'b1;
            end else if (SBE_CLR) begin
                SBE_IRQ <= 1'b0;
            end
            if (mbe_ev) begin
                MBE_IRQ <= 1'b1;
            end else if (MBE_CLR) begin
                MBE_IRQ <= 1'b0;
            end
            if (sbe_ev && (!SBE_IRQ || SBE_CLR)) begin
                SBE_ADDR <= last_addr_q;
            end
            if (mbe_ev && (!MBE_IRQ || MBE_CLR)) begin
                MBE_ADDR <= last_addr_q;
            end
        end
    end
endmodule

// ---- crw_chk.sv ----
// Port checker for the coupled RAM wrapper.
// Assumes it is bound onto crw_top and sees only its ports.
`timescale 1ns/1ns
// ============================================================
// Checker
module crw_chk #(
    parameter AW = 12
) (
    input wire CLK,
    input wire NRST,
    input wire REQ,
    input wire WR,
    input wire [AW-1:0] ADDR,
    input wire ADDR_PAR,
    input wire [7:0] BE,
    input wire [1:0] EVENT,
    input wire SBE_CLR,
    input wire MBE_CLR,
    input wire READY,
    input wire RVALID,
    input wire SBE_IRQ,
    input wire MBE_IRQ,
    input wire [AW-1:0] SBE_ADDR,
    input wire [AW-1:0] MBE_ADDR,
    input wire ADDR_PAR_ERR,
    input wire INIT_BUSY,
    input wire [1:0] BANK_CS,
    input wire [1:0] ECC_CS,
    input wire [7:0] BANK_WE
);
    // One clock, one reset for all checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    property p_rd; REQ && READY |=> RVALID == !$past(WR); endproperty
    a_rd: assert property (p_rd) else $error("read answer wrong");
    property p_par;
        REQ && READY |=> ADDR_PAR_ERR == ($past(ADDR_PAR) ^ (^$past(ADDR)));
    endproperty
    a_par: assert property (p_par) else $error("parity flag wrong");
    property p_sbe; EVENT[0] |=> SBE_IRQ; endproperty
    a_sbe: assert property (p_sbe) else $error("single flag missing");
    property p_mbe; EVENT[1] |=> MBE_IRQ; endproperty
    a_mbe: assert property (p_mbe) else $error("multi flag missing");
    property p_sbe_hold; SBE_IRQ && !SBE_CLR |=> SBE_IRQ && $stable(SBE_ADDR); endproperty
    a_sbe_hold: assert property (p_sbe_hold) else $error("single flag lost");
    property p_mbe_hold; MBE_IRQ && !MBE_CLR |=> MBE_IRQ && $stable(MBE_ADDR); endproperty
    a_mbe_hold: assert property (p_mbe_hold) else $error("multi flag lost");
    property p_we; REQ && READY && WR |-> BANK_WE == BE; endproperty
    a_we: assert property (p_we) else $error("lane enables wrong");
    property p_rd_we; REQ && READY && !WR |-> BANK_WE == 8'h00; endproperty
    a_rd_we: assert property (p_rd_we) else $error("write on read");
    property p_cs_rd;
        REQ && READY && !WR |-> BANK_CS == 2'b11 && ECC_CS == 2'b11;
    endproperty
    a_cs_rd: assert property (p_cs_rd) else $error("read selects wrong");
    property p_cs_wr;
        REQ && READY && WR |-> BANK_CS == {|(BE & 8'haa), |(BE & 8'h55)};
    endproperty
    a_cs_wr: assert property (p_cs_wr) else $error("write selects wrong");
    property p_init_we;
        INIT_BUSY |-> BANK_WE == 8'hff && BANK_CS == 2'b11 && ECC_CS == 2'b11;
    endproperty
    a_init_we: assert property (p_init_we) else $error("init write missing");
endmodule
bind crw_top crw_chk #(.AW(AW)) u_chk (.CLK(CLK), .NRST(NRST), .REQ(REQ), .WR(WR),
    .ADDR(ADDR), .ADDR_PAR(ADDR_PAR), .BE(BE), .EVENT(EVENT), .SBE_CLR(SBE_CLR),
    .MBE_CLR(MBE_CLR), .READY(READY), .RVALID(RVALID), .SBE_IRQ(SBE_IRQ),
    .MBE_IRQ(MBE_IRQ), .SBE_ADDR(SBE_ADDR), .MBE_ADDR(MBE_ADDR),
    .ADDR_PAR_ERR(ADDR_PAR_ERR), .INIT_BUSY(INIT_BUSY), .BANK_CS(BANK_CS),
    .ECC_CS(ECC_CS), .BANK_WE(BANK_WE));

// ---- crw_core.sv ----
// Core side model of the secondary memory port.
// Assumes its tasks are called just after a rising CLK edge.
`timescale 1ns/1ns
// ============================================================
// Core model
module crw_core #(
    parameter AW = 12
) (
    input wire CLK,
    output logic REQ,
    output logic WR,
    output logic [AW-1:0] ADDR,
    output logic ADDR_PAR,
    output logic [7:0] BE,
    output logic [63:0] WDATA,
    output logic [7:0] WECC,
    output logic [1:0] EVENT
);
    // Quiet port at time zero
    initial begin
        {REQ, WR, ADDR, ADDR_PAR, BE, WDATA, WECC, EVENT} = '0;
    end
    // One access, held through its taking edge
    task acc(input logic w, input logic [AW-1:0] a, input logic [7:0] b,
             input logic [63:0] d, input logic [7:0] e, input logic bad);
        {REQ, WR, ADDR, BE, WDATA, WECC} = {1'b1, w, a, b, d, e};
        ADDR_PAR = (^a) ^ bad;
        @(posedge CLK);
        #1;
    endtask
    // Released address and data lines flip so stale values never match
    task idle();
        REQ = 1'b0;
        {ADDR, WDATA} = ~{ADDR, WDATA};
        @(posedge CLK);
        #1;
    endtask
    // One-cycle ECC event from a core with signalling on
    task ev(input logic [1:0] b);
        EVENT = b;
        @(posedge CLK);
        #1;
        EVENT = 2'h0;
    endtask
endmodule

// ---- tightly_coupled_ram_ecc_wrapper_tb.sv ----
// Self-checking bench for the coupled RAM wrapper.
// Assumes crw_top, crw_core and crw_chk in this folder.
`timescale 1ns/1ns
// ============================================================
// Bench
module tightly_coupled_ram_ecc_wrapper_tb;
    localparam AW = 4;
    logic CLK, NRST, INIT_GLOBAL_EN, SBE_CLR, MBE_CLR;
    logic [15:0] INIT_SELECT;
    wire REQ, WR, ADDR_PAR, READY, RVALID, SBE_IRQ, MBE_IRQ, ADDR_PAR_ERR;
    wire INIT_BUSY, INIT_DONE, DECODE_ERR;
    wire [AW-1:0] ADDR, SBE_ADDR, MBE_ADDR;
    wire [7:0] BE, WECC, RECC, BANK_WE;
    wire [63:0] WDATA, RDATA;
    wire [1:0] EVENT, BANK_CS, ECC_CS;
    logic [71:0] mem [0:15];
    logic [71:0] q [$];
    int miscompares, tests_run, n;
    // 50 MHz clock
    initial begin
        CLK = 0;
        forever #10 CLK = ~CLK;
    end
    crw_core #(.AW(AW)) u_core (.CLK(CLK), .REQ(REQ), .WR(WR), .ADDR(ADDR),
        .ADDR_PAR(ADDR_PAR), .BE(BE), .WDATA(WDATA), .WECC(WECC), .EVENT(EVENT));
    crw_top #(.AW(AW)) u_dut (.CLK(CLK), .NRST(NRST), .REQ(REQ), .WR(WR), .ADDR(ADDR),
        .ADDR_PAR(ADDR_PAR), .BE(BE), .WDATA(WDATA), .WECC(WECC), .EVENT(EVENT),
        .INIT_GLOBAL_EN(INIT_GLOBAL_EN), .INIT_SELECT(INIT_SELECT), .SBE_CLR(SBE_CLR),
        .MBE_CLR(MBE_CLR), .READY(READY), .RDATA(RDATA), .RECC(RECC), .RVALID(RVALID),
        .SBE_IRQ(SBE_IRQ), .MBE_IRQ(MBE_IRQ), .SBE_ADDR(SBE_ADDR), .MBE_ADDR(MBE_ADDR),
        .ADDR_PAR_ERR(ADDR_PAR_ERR), .DECODE_ERR(DECODE_ERR), .INIT_BUSY(INIT_BUSY),
        .INIT_DONE(INIT_DONE), .BANK_CS(BANK_CS), .ECC_CS(ECC_CS), .BANK_WE(BANK_WE));
    task chk(input string nm, input logic [71:0] s, input logic [71:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task summarize();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task rd(input int a);
        u_core.acc(0, a[AW-1:0], 8'h00, 64'h0, 8'h00, 0);
        q.push_back(mem[a]);
    endtask
    task wr(input int a, input logic [7:0] b);
        logic [63:0] d;
        logic [7:0] ec;
        d = {$urandom, $urandom};
        ec = 8'($urandom);
        u_core.acc(1, a[AW-1:0], b, d, ec, 0);
        for (int k = 0; k < 8; k++) if (b[k]) mem[a][8*k +: 8] = d[8*k +: 8];
        mem[a][71:64] = ec;
    endtask
    task evchk(input int b);
        logic [1:0] m;
        m = 2'b01 << b;
        rd(4 + b);
        u_core.idle();
        u_core.ev(m);
        chk("irq_set", b ? MBE_IRQ : SBE_IRQ, 1);
        chk("err_addr", b ? MBE_ADDR : SBE_ADDR, 4 + b);
        rd(9);
        u_core.idle();
        u_core.ev(m);
        chk("err_addr_held", b ? MBE_ADDR : SBE_ADDR, 4 + b);
        {MBE_CLR, SBE_CLR} = m;
        u_core.idle();
        {MBE_CLR, SBE_CLR} = 2'b00;
        chk("irq_clear", b ? MBE_IRQ : SBE_IRQ, 0);
        u_core.ev(m);
        chk("err_addr_new", b ? MBE_ADDR : SBE_ADDR, 9);
        rd(3);
        u_core.idle();
        {MBE_CLR, SBE_CLR} = m;
        u_core.ev(m);
        {MBE_CLR, SBE_CLR} = 2'b00;
        chk("irq_set_wins", b ? MBE_IRQ : SBE_IRQ, 1);
        chk("err_addr_recap", b ? MBE_ADDR : SBE_ADDR, 3);
    endtask
    // Read answers against oldest note
    always @(posedge CLK) begin
        if (RVALID === 1'b1) chk("read_word", {RECC, RDATA}, q.size() ? q.pop_front() : 'x);
        if (NRST === 1'b1 && DECODE_ERR !== 1'b0) chk("decode_err", DECODE_ERR, 0);
    end
    // Hang guard
    initial begin
        repeat (3000) @(posedge CLK);
        #2;
        miscompares++;
        summarize();
    end
    // Main sequence
    initial begin
        {NRST, INIT_GLOBAL_EN, SBE_CLR, MBE_CLR, INIT_SELECT} = '0;
        n = $urandom(32'hf359);
        repeat (6) @(posedge CLK);
        #1;
        NRST = 1;
        chk("ready_busy", {READY, INIT_BUSY}, 2'b10);
        INIT_GLOBAL_EN = 1;
        INIT_SELECT = 16'hfffe;
        repeat (3) u_core.idle();
        chk("busy_unselected", INIT_BUSY, 0);
        INIT_SELECT = 16'h0001;
        u_core.idle();
        INIT_GLOBAL_EN = 0;
        for (n = 0; n < 100 && INIT_BUSY === 1'b1; n++) u_core.idle();
        chk("init_cycles", n, 16);
        for (n = 0; n < 16; n++) mem[n] = '0;
        for (n = 0; n < 16; n++) rd(n);
        chk("init_done", {INIT_DONE, READY}, 2'b11);
        for (n = 0; n < 16; n++) wr(n, 8'hff);
        for (n = 15; n >= 0; n--) rd(n);
        for (n = 0; n < 8; n++) begin
            wr(n, 8'h01 << n);
            rd(n);
        end
        u_core.idle();
        for (n = 0; n < 2; n++) evchk(n);
        u_core.acc(1, 4'h3, 8'h00, 64'h0, 8'h00, 1);
        chk("par_err", ADDR_PAR_ERR, 1);
        u_core.idle();
        chk("par_clear", ADDR_PAR_ERR, 0);
        chk("pending", q.size(), 0);
        summarize();
    end
endmodule
